//--- hdl/host_port_pkg.sv
package host_port_pkg;
  // slave cpu addresses
  localparam logic [15:0] ADDR_SERIAL_TIMER_CONTROL = 16'hffc3;
  localparam logic [15:0] ADDR_SYSTEM_CONTROL = 16'hffc4;
  localparam logic [15:0] ADDR_HOST_PORT_CONTROL = 16'hfff0;
  localparam logic [15:0] ADDR_IN_BYTE_CH1 = 16'hfff4;
  localparam logic [15:0] ADDR_OUT_BYTE_CH1 = 16'hfff5;
  localparam logic [15:0] ADDR_FLAGS_CH1 = 16'hfff6;
  localparam logic [15:0] ADDR_IN_BYTE_CH2 = 16'hfffc;
  localparam logic [15:0] ADDR_OUT_BYTE_CH2 = 16'hfffd;
  localparam logic [15:0] ADDR_FLAGS_CH2 = 16'hfffe;
  // reset values
  localparam logic [7:0] RST_SERIAL_TIMER_CONTROL = 8'h00;
  localparam logic [7:0] RST_SYSTEM_CONTROL = 8'h09;
  localparam logic [7:0] RST_HOST_PORT_CONTROL = 8'hf8;
  localparam logic [7:0] RST_FLAGS = 8'h00;
  // field positions
  localparam int SYSCTL_RESET_SOURCE_BIT = 3;
  localparam int SYSCTL_HOST_PORT_ENABLE_BIT = 1;
  localparam int STCTL_ALT_PIN_SELECT_BIT = 0;
  localparam int CTL_RX_IRQ_EN_CH2_BIT = 2;
  localparam int CTL_RX_IRQ_EN_CH1_BIT = 1;
  localparam int CTL_FAST_GATE_BIT = 0;
  localparam logic [7:0] CTL_FIXED_ONES = 8'hf8;
  localparam logic [7:0] FLAGS_USER_MASK = 8'hf4;
  localparam int FLAGS_CMD_BIT = 3;
  localparam int FLAGS_RX_FULL_BIT = 1;
  localparam int FLAGS_TX_FULL_BIT = 0;
  // host write queue
  localparam int HOST_FIFO_DEPTH = 8;
  localparam int HOST_FIFO_WIDTH = 10;
endpackage

//--- hdl/host_wr_fifo.sv
`timescale 1ns/1ps
`default_nettype none
module host_wr_fifo #(
  parameter int WIDTH = 10,
  parameter int DEPTH = 8
) (
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;

  assign in_ready_o = (count != (AW+1)'(DEPTH));
  assign out_valid_o = (count != '0);
  assign out_data_o = mem[rd_ptr];

  always_ff @(posedge clk_sys_i)
  begin
    if (push)
    begin
      mem[wr_ptr] <= in_data_i;
    end
  end

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
    end
    else
    begin
      if (push)
      begin
        wr_ptr <= (wr_ptr == AW'(DEPTH-1)) ? '0 : wr_ptr + 1'b1;
      end
      if (pop)
      begin
        rd_ptr <= (rd_ptr == AW'(DEPTH-1)) ? '0 : rd_ptr + 1'b1;
      end
      count <= count + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  a_fifo_bounds: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    count <= (AW+1)'(DEPTH))
    else $error("fifo count beyond depth");
endmodule
`default_nettype wire

//--- hdl/dual_channel_host_slave_port.sv
// What this block does
// - channel one select low: write edge captures byte
// - address-select stored as command/data flag
// - input byte readable by cpu only
// - host selects decoded from select pins
// - cpu reaches registers at fixed addresses
// - flags: only user bits cpu writable
// - enable bit gates all host transfers
// - system control resets 09, bit3 read-only
// - port control resets f8, cpu only
// - port control bits 7..3 read one
// - control bit 2 gates channel-two interrupt
// - control bit 1 gates channel-one interrupt
// - control bit 0 selects fast gate
// - input bytes have no reset value
// - rx full set by write, cleared by read
// - output byte driven during host read with address-select low
// - tx full set by cpu, cleared by host
// - pin select chooses alternate write strobe and channel-two select pins
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_slave_port
  import host_port_pkg::*;
(
  input wire logic clk_sys_i,
  input wire logic rstn_i,
  input wire logic hw_standby_i,
  // slave cpu register port
  input wire logic [15:0] cpu_addr_i,
  input wire logic cpu_wr_i,
  input wire logic cpu_rd_i,
  input wire logic [7:0] cpu_wdata_i,
  output logic [7:0] cpu_rdata_o,
  // host pins
  input wire logic channel_one_select_n_i,
  input wire logic channel_two_select_n_i,
  input wire logic alt_channel_two_select_n_i,
  input wire logic host_addr_select_i,
  input wire logic host_read_strobe_n_i,
  input wire logic host_write_strobe_n_i,
  input wire logic alt_host_write_strobe_n_i,
  input wire logic [7:0] host_data_bus_i,
  output logic [7:0] host_data_bus_o,
  output logic host_data_bus_oe_o,
  // gate, interrupts and queue ready
  input wire logic gate_sw_level_i,
  input wire logic gate_fast_level_i,
  output logic gate_a20_out_o,
  output logic rx_full_irq_ch1_o,
  output logic rx_full_irq_ch2_o,
  output logic host_fifo_ready_o
);
  // pin synchronisers: 15 bits {data, ha0, ior, iow, aiow, cs1, cs2, acs2}
  localparam int PW = 15;
  logic [PW-1:0] pin_meta;
  logic [PW-1:0] pin_sync;
  logic ior_prev;
  logic iow_prev;
  wire [PW-1:0] pin_raw = {host_data_bus_i, host_addr_select_i, host_read_strobe_n_i,
    host_write_strobe_n_i, alt_host_write_strobe_n_i, channel_one_select_n_i,
    channel_two_select_n_i, alt_channel_two_select_n_i};

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      pin_meta <= {8'h00, 7'h7f};
      pin_sync <= {8'h00, 7'h7f};
    end
    else
    begin
      pin_meta <= pin_raw;
      pin_sync <= pin_meta;
    end
  end

  // registers
  logic [7:0] serial_timer_control;
  logic [7:0] system_control;
  logic [2:0] host_port_control;
  logic [7:0] host_in_byte [2];
  logic [7:0] host_out_byte [2];
  logic [7:0] user_spare_bits [2];
  logic [1:0] cmd_flag;
  logic [1:0] rx_full_flag;
  logic [1:0] tx_full_flag;

  wire [7:0] s_data = pin_sync[14:7];
  wire s_ha0 = pin_sync[6];
  wire s_ior_n = pin_sync[5];
  wire alt_pin_select = serial_timer_control[STCTL_ALT_PIN_SELECT_BIT];
  wire s_iow_n = alt_pin_select ? pin_sync[3] : pin_sync[4];
  wire s_cs1_n = pin_sync[2];
  wire s_cs2_n = alt_pin_select ? pin_sync[0] : pin_sync[1];
  wire host_port_enable = system_control[SYSCTL_HOST_PORT_ENABLE_BIT];
  wire rx_full_irq_en_ch1 = host_port_control[CTL_RX_IRQ_EN_CH1_BIT];
  wire rx_full_irq_en_ch2 = host_port_control[CTL_RX_IRQ_EN_CH2_BIT];
  wire fast_gate_enable = host_port_control[CTL_FAST_GATE_BIT];

  // host decode
  wire sel_ch1 = !s_cs1_n && s_cs2_n;
  wire sel_ch2 = s_cs1_n && !s_cs2_n;
  wire sel_any = host_port_enable && (sel_ch1 || sel_ch2);
  wire sel_idx = sel_ch2;
  wire iow_rise = s_iow_n && !iow_prev;
  wire ior_rise = s_ior_n && !ior_prev;
  wire host_wr_event = sel_any && iow_rise;
  wire host_rd_odr_done = sel_any && ior_rise && !s_ha0;

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      iow_prev <= 1'b1;
      ior_prev <= 1'b1;
    end
    else
    begin
      iow_prev <= s_iow_n;
      ior_prev <= s_ior_n;
    end
  end

  // host write queue {channel, ha0, data}
  logic fifo_out_valid;
  logic [HOST_FIFO_WIDTH-1:0] fifo_out_data;
  wire fifo_ch = fifo_out_data[9];
  wire fifo_drain = fifo_out_valid && !rx_full_flag[fifo_ch];

  host_wr_fifo #(
    .WIDTH(HOST_FIFO_WIDTH),
    .DEPTH(HOST_FIFO_DEPTH)
  ) u_wr_fifo (
    .clk_sys_i(clk_sys_i),
    .rstn_i(rstn_i),
    .in_valid_i(host_wr_event),
    .in_ready_o(host_fifo_ready_o),
    .in_data_i({sel_idx, s_ha0, s_data}),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(!rx_full_flag[fifo_ch]),
    .out_data_o(fifo_out_data)
  );

  // cpu decode
  wire hit_stc = cpu_addr_i == ADDR_SERIAL_TIMER_CONTROL;
  wire hit_sys = cpu_addr_i == ADDR_SYSTEM_CONTROL;
  wire hit_ctl = cpu_addr_i == ADDR_HOST_PORT_CONTROL;
  wire [1:0] hit_in = {cpu_addr_i == ADDR_IN_BYTE_CH2, cpu_addr_i == ADDR_IN_BYTE_CH1};
  wire [1:0] hit_out = {cpu_addr_i == ADDR_OUT_BYTE_CH2, cpu_addr_i == ADDR_OUT_BYTE_CH1};
  wire [1:0] hit_flg = {cpu_addr_i == ADDR_FLAGS_CH2, cpu_addr_i == ADDR_FLAGS_CH1};
  wire [7:0] ctl_view = CTL_FIXED_ONES | {5'h00, host_port_control};
  wire sys_rst = hw_standby_i;

  function automatic logic [7:0] flags_view(input logic [7:0] user, input logic cd,
    input logic rxf, input logic txf);
    logic [7:0] v;
    v = user & FLAGS_USER_MASK;
    v[FLAGS_CMD_BIT] = cd;
    v[FLAGS_RX_FULL_BIT] = rxf;
    v[FLAGS_TX_FULL_BIT] = txf;
    return v;
  endfunction

  wire [7:0] flags_ch1 = flags_view(user_spare_bits[0], cmd_flag[0], rx_full_flag[0], tx_full_flag[0]);
  wire [7:0] flags_ch2 = flags_view(user_spare_bits[1], cmd_flag[1], rx_full_flag[1], tx_full_flag[1]);
  wire [7:0] cpu_read_mux =
    hit_stc ? serial_timer_control :
    hit_sys ? system_control :
    hit_ctl ? ctl_view :
    hit_in[0] ? host_in_byte[0] :
    hit_in[1] ? host_in_byte[1] :
    hit_out[0] ? host_out_byte[0] :
    hit_out[1] ? host_out_byte[1] :
    hit_flg[0] ? flags_ch1 :
    hit_flg[1] ? flags_ch2 : 8'h00;

  // control registers
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      serial_timer_control <= RST_SERIAL_TIMER_CONTROL;
      system_control <= RST_SYSTEM_CONTROL;
      host_port_control <= RST_HOST_PORT_CONTROL[2:0];
    end
    else if (sys_rst)
    begin
      serial_timer_control <= RST_SERIAL_TIMER_CONTROL;
      system_control <= RST_SYSTEM_CONTROL;
      host_port_control <= RST_HOST_PORT_CONTROL[2:0];
    end
    else if (cpu_wr_i)
    begin
      if (hit_stc)
      begin
        serial_timer_control <= cpu_wdata_i;
      end
      if (hit_sys)
      begin
        system_control <= {cpu_wdata_i[7:4], system_control[SYSCTL_RESET_SOURCE_BIT],
          cpu_wdata_i[2:0]};
      end
      if (hit_ctl)
      begin
        host_port_control <= cpu_wdata_i[2:0];
      end
    end
  end

  // data bytes carry no reset value
  always_ff @(posedge clk_sys_i)
  begin
    if (fifo_drain)
    begin
      host_in_byte[fifo_ch] <= fifo_out_data[7:0];
    end
    for (int c = 0; c < 2; c++)
    begin
      if (cpu_wr_i && hit_out[c])
      begin
        host_out_byte[c] <= cpu_wdata_i;
      end
    end
  end

  // status flags
  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      for (int c = 0; c < 2; c++)
      begin
        user_spare_bits[c] <= RST_FLAGS;
      end
      cmd_flag <= '0;
      rx_full_flag <= '0;
      tx_full_flag <= '0;
    end
    else if (sys_rst)
    begin
      for (int c = 0; c < 2; c++)
      begin
        user_spare_bits[c] <= RST_FLAGS;
      end
      cmd_flag <= '0;
      rx_full_flag <= '0;
      tx_full_flag <= '0;
    end
    else
    begin
      for (int c = 0; c < 2; c++)
      begin
        if (cpu_wr_i && hit_flg[c])
        begin
          user_spare_bits[c] <= cpu_wdata_i & FLAGS_USER_MASK;
        end
        if (fifo_drain && fifo_ch == c[0])
        begin
          cmd_flag[c] <= fifo_out_data[8];
          rx_full_flag[c] <= 1'b1;
        end
        else if (cpu_rd_i && hit_in[c])
        begin
          rx_full_flag[c] <= 1'b0;
        end
        if (cpu_wr_i && hit_out[c])
        begin
          tx_full_flag[c] <= 1'b1;
        end
        else if (host_rd_odr_done && sel_idx == c[0])
        begin
          tx_full_flag[c] <= 1'b0;
        end
      end
    end
  end

  // cpu read data and host read drive
  wire host_reading = sel_any && !s_ior_n;
  wire [7:0] host_read_mux = s_ha0 ? (sel_idx ? flags_ch2 : flags_ch1)
    : host_out_byte[sel_idx];

  always_ff @(posedge clk_sys_i or negedge rstn_i)
  begin
    if (!rstn_i)
    begin
      cpu_rdata_o <= 8'h00;
      host_data_bus_o <= 8'h00;
      host_data_bus_oe_o <= 1'b0;
    end
    else
    begin
      if (cpu_rd_i)
      begin
        cpu_rdata_o <= cpu_read_mux;
      end
      host_data_bus_o <= host_read_mux;
      host_data_bus_oe_o <= host_reading;
    end
  end

  assign gate_a20_out_o = fast_gate_enable ? gate_fast_level_i : gate_sw_level_i;
  assign rx_full_irq_ch1_o = rx_full_flag[0] && rx_full_irq_en_ch1;
  assign rx_full_irq_ch2_o = rx_full_flag[1] && rx_full_irq_en_ch2;

  a_irq_gate_one: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rx_full_irq_ch1_o == (rx_full_flag[0] && host_port_control[1]))
    else $error("channel one interrupt not gated");
  a_irq_gate_two: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    rx_full_irq_ch2_o == (rx_full_flag[1] && host_port_control[2]))
    else $error("channel two interrupt not gated");
  a_ctl_read_ones: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    cpu_rd_i && hit_ctl |=> cpu_rdata_o[7:3] == 5'h1f)
    else $error("control high bits not one");
  a_sys_bit_fixed: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !sys_rst |=> $stable(system_control[3]))
    else $error("system control bit 3 changed");
  a_rx_clear_read: assert property (@(posedge clk_sys_i) disable iff (!rstn_i || sys_rst)
    cpu_rd_i && hit_in[0] && !(fifo_drain && !fifo_ch) |=> !rx_full_flag[0])
    else $error("rx full not cleared by read");
  a_rx_set_drain: assert property (@(posedge clk_sys_i) disable iff (!rstn_i || sys_rst)
    fifo_drain |=> rx_full_flag[$past(fifo_ch)] && cmd_flag[$past(fifo_ch)] == $past(fifo_out_data[8]))
    else $error("drain did not set flags");
  a_tx_set_write: assert property (@(posedge clk_sys_i) disable iff (!rstn_i || sys_rst)
    cpu_wr_i && hit_out[1] |=> tx_full_flag[1])
    else $error("tx full not set");
  a_drive_needs_en: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    !host_port_enable ##1 !host_port_enable |-> !host_data_bus_oe_o)
    else $error("bus driven while port disabled");
  a_user_bits_only: assert property (@(posedge clk_sys_i) disable iff (!rstn_i || sys_rst)
    cpu_wr_i && hit_flg[0] |=> (flags_ch1 & FLAGS_USER_MASK) == ($past(cpu_wdata_i) & FLAGS_USER_MASK)
      && user_spare_bits[0][3] == 1'b0)
    else $error("non-user flag bit stored");
  a_tx_clear_host: assert property (@(posedge clk_sys_i) disable iff (!rstn_i || sys_rst)
    host_rd_odr_done && !sel_idx && !(cpu_wr_i && hit_out[0]) |=> !tx_full_flag[0])
    else $error("tx full not cleared by host read");
  a_no_dual_select: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    s_cs1_n == s_cs2_n |-> !host_wr_event)
    else $error("write taken without a single select");
  a_in_byte_load: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    fifo_drain && !fifo_ch |=> host_in_byte[0] == $past(fifo_out_data[7:0]))
    else $error("input byte not loaded");
  a_out_byte_drive: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
    sel_any && !s_ior_n && !s_ha0 |=> host_data_bus_oe_o && host_data_bus_o == $past(host_out_byte[sel_idx]))
    else $error("output byte not driven");
endmodule
`default_nettype wire

//--- verif/host_model.sv
`timescale 1ns/1ps
`default_nettype none
module host_model (
  input wire logic clk_i,
  input wire logic [7:0] dev_data_i,
  output logic cs1_n_o,
  output logic cs2_n_o,
  output logic alt_cs2_n_o,
  output logic ha0_o,
  output logic rd_n_o,
  output logic wr_n_o,
  output logic alt_wr_n_o,
  output logic [7:0] data_o
);
  logic drive;
  logic [7:0] drv;
  // released bus shows the inverse of the last byte
  assign data_o = drive ? drv : ~drv;
  initial
  begin
    {cs1_n_o, cs2_n_o, alt_cs2_n_o, rd_n_o, wr_n_o, alt_wr_n_o} = 6'h3f;
    ha0_o = 1'b0;
    drive = 1'b0;
    drv = 8'h00;
  end
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // sel_n is {cs1, cs2, alt cs2}
  task automatic host_write(input logic [2:0] sel_n, input logic alt, input logic ha, input logic [7:0] d);
    {cs1_n_o, cs2_n_o, alt_cs2_n_o} = sel_n;
    ha0_o = ha;
    drv = d;
    drive = 1'b1;
    cyc(1);
    if (alt)
      alt_wr_n_o = 1'b0;
    else
      wr_n_o = 1'b0;
    cyc(4);
    wr_n_o = 1'b1;
    alt_wr_n_o = 1'b1;
    cyc(4);
    {cs1_n_o, cs2_n_o, alt_cs2_n_o} = 3'h7;
    drive = 1'b0;
  endtask
  task automatic host_read(input logic [2:0] sel_n, input logic ha, output logic [7:0] d);
    {cs1_n_o, cs2_n_o, alt_cs2_n_o} = sel_n;
    ha0_o = ha;
    cyc(1);
    rd_n_o = 1'b0;
    cyc(5);
    d = dev_data_i;
    rd_n_o = 1'b1;
    cyc(4);
    {cs1_n_o, cs2_n_o, alt_cs2_n_o} = 3'h7;
    cyc(1);
  endtask
endmodule
`default_nettype wire

//--- verif/dual_channel_host_slave_port_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module dual_channel_host_slave_port_tb_top;
  import host_port_pkg::*;
  logic clk_sys_i, rstn_i, stby, wr, rd, cs1, cs2, acs2, ha0, rdn, wrn, awrn, oe;
  logic gsw, gfast, gate, irq1, irq2, fready, saw_full;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, bus_i, bus_o, host_bus, v;
  int mismatches, n_checks;
  assign bus_i = oe ? bus_o : host_bus;
  dual_channel_host_slave_port i_dual_channel_host_slave_port (
    .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .hw_standby_i(stby),
    .cpu_addr_i(addr), .cpu_wr_i(wr), .cpu_rd_i(rd), .cpu_wdata_i(wdata), .cpu_rdata_o(rdata),
    .channel_one_select_n_i(cs1), .channel_two_select_n_i(cs2), .alt_channel_two_select_n_i(acs2),
    .host_addr_select_i(ha0), .host_read_strobe_n_i(rdn), .host_write_strobe_n_i(wrn),
    .alt_host_write_strobe_n_i(awrn), .host_data_bus_i(bus_i), .host_data_bus_o(bus_o),
    .host_data_bus_oe_o(oe), .gate_sw_level_i(gsw), .gate_fast_level_i(gfast), .gate_a20_out_o(gate),
    .rx_full_irq_ch1_o(irq1), .rx_full_irq_ch2_o(irq2), .host_fifo_ready_o(fready)
  );
  host_model i_host_model (
    .clk_i(clk_sys_i), .dev_data_i(bus_i), .cs1_n_o(cs1), .cs2_n_o(cs2), .alt_cs2_n_o(acs2),
    .ha0_o(ha0), .rd_n_o(rdn), .wr_n_o(wrn), .alt_wr_n_o(awrn), .data_o(host_bus)
  );
  initial
  begin
    clk_sys_i = 1'b0;
    forever #20 clk_sys_i = ~clk_sys_i;
  end
  always @(posedge clk_sys_i)
    if (fready === 1'b0)
      saw_full <= 1'b1;
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
    #1;
  endtask
  task automatic check_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic check_bit(input string nm, input logic e, input logic g);
    n_checks++;
    if (g !== e)
    begin
      $display("[FAIL] %s expected %b seen %b", nm, e, g);
      mismatches++;
    end
  endtask
  task automatic cpu_wr(input logic [15:0] a, input logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    tick(1);
    wr = 1'b0;
    tick(1);
  endtask
  task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string nm);
    addr = a;
    rd = 1'b1;
    tick(1);
    rd = 1'b0;
    tick(1);
    check_byte(nm, e, rdata);
  endtask
  task automatic hw(input logic [2:0] s, input logic alt, input logic ha, input logic [7:0] d);
    i_host_model.host_write(s, alt, ha, d);
    tick(3);
  endtask
  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  initial
  begin
    #(40 * 20000);
    $display("[FAIL] run time expected done seen hang");
    mismatches++;
    tally_and_finish;
  end
  initial
  begin
    {rstn_i, stby, wr, rd, gfast, saw_full} = 6'h00;
    gsw = 1'b1;
    addr = 16'h0000;
    wdata = 8'h00;
    tick(3);
    rstn_i = 1'b1;
    tick(3);
    rd_chk(ADDR_SYSTEM_CONTROL, 8'h09, "sysctl rst");
    rd_chk(ADDR_HOST_PORT_CONTROL, 8'hf8, "ctl rst");
    rd_chk(ADDR_SERIAL_TIMER_CONTROL, 8'h00, "stctl rst");
    rd_chk(ADDR_FLAGS_CH1, 8'h00, "flags1 rst");
    rd_chk(ADDR_FLAGS_CH2, 8'h00, "flags2 rst");
    rd_chk(16'hfff1, 8'h00, "unmapped");
    check_bit("gate sw", 1'b1, gate);
    cpu_wr(ADDR_HOST_PORT_CONTROL, 8'h00);
    rd_chk(ADDR_HOST_PORT_CONTROL, 8'hf8, "ctl ones");
    cpu_wr(ADDR_SYSTEM_CONTROL, 8'h00);
    rd_chk(ADDR_SYSTEM_CONTROL, 8'h08, "sysctl bit3");
    hw(3'b011, 1'b0, 1'b1, 8'h11);
    rd_chk(ADDR_FLAGS_CH1, 8'h00, "disabled write");
    cpu_wr(ADDR_SYSTEM_CONTROL, 8'h02);
    rd_chk(ADDR_SYSTEM_CONTROL, 8'h0a, "enable");
    hw(3'b011, 1'b0, 1'b1, 8'ha5);
    rd_chk(ADDR_FLAGS_CH1, 8'h0a, "flags1 cmd");
    check_bit("irq1 masked", 1'b0, irq1);
    cpu_wr(ADDR_HOST_PORT_CONTROL, 8'h02);
    check_bit("irq1 on", 1'b1, irq1);
    rd_chk(ADDR_IN_BYTE_CH1, 8'ha5, "in1");
    rd_chk(ADDR_FLAGS_CH1, 8'h08, "flags1 clr");
    check_bit("irq1 off", 1'b0, irq1);
    hw(3'b101, 1'b0, 1'b0, 8'h3c);
    rd_chk(ADDR_FLAGS_CH2, 8'h02, "flags2 data");
    check_bit("irq2 masked", 1'b0, irq2);
    cpu_wr(ADDR_HOST_PORT_CONTROL, 8'h04);
    check_bit("irq2 on", 1'b1, irq2);
    rd_chk(ADDR_IN_BYTE_CH2, 8'h3c, "in2");
    hw(3'b001, 1'b0, 1'b1, 8'hee);
    rd_chk(ADDR_FLAGS_CH1, 8'h08, "both sel f1");
    rd_chk(ADDR_FLAGS_CH2, 8'h00, "both sel f2");
    cpu_wr(ADDR_SERIAL_TIMER_CONTROL, 8'h01);
    hw(3'b110, 1'b1, 1'b0, 8'h77);
    rd_chk(ADDR_IN_BYTE_CH2, 8'h77, "alt pins");
    cpu_wr(ADDR_SERIAL_TIMER_CONTROL, 8'h00);
    cpu_wr(ADDR_FLAGS_CH1, 8'hff);
    rd_chk(ADDR_FLAGS_CH1, 8'hfc, "user bits");
    cpu_wr(ADDR_OUT_BYTE_CH1, 8'h5a);
    rd_chk(ADDR_FLAGS_CH1, 8'hfd, "tx set");
    i_host_model.host_read(3'b011, 1'b1, v);
    check_byte("host status", 8'hfd, v);
    i_host_model.host_read(3'b011, 1'b0, v);
    check_byte("host out1", 8'h5a, v);
    rd_chk(ADDR_FLAGS_CH1, 8'hfc, "tx clr");
    cpu_wr(ADDR_HOST_PORT_CONTROL, 8'h01);
    check_bit("gate fast", 1'b0, gate);
    stby = 1'b1;
    tick(1);
    stby = 1'b0;
    tick(1);
    rd_chk(ADDR_HOST_PORT_CONTROL, 8'hf8, "ctl stby");
    rd_chk(ADDR_SYSTEM_CONTROL, 8'h09, "sysctl stby");
    rd_chk(ADDR_FLAGS_CH1, 8'h00, "flags stby");
    cpu_wr(ADDR_SYSTEM_CONTROL, 8'h02);
    for (int i = 0; i < 10; i++)
      hw(3'b011, 1'b0, 1'b0, 8'(i));
    check_bit("queue refused", 1'b1, saw_full);
    for (int i = 0; i < 9; i++)
    begin
      rd_chk(ADDR_IN_BYTE_CH1, 8'(i), "queued byte");
      tick(3);
    end
    rd_chk(ADDR_FLAGS_CH1, 8'h00, "queue empty");
    tally_and_finish;
  end
endmodule
`default_nettype wire
